// File: test/breaker_remote_model.sv
// Breaker pole contacts and remote permissive channel facing the trip block.
`timescale 1ns/10ps
module breaker_remote_model #(
	parameter int OPEN_DLY  = 6,
	parameter int CLOSE_DLY = 4
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Commands from the block and the bench
	input  wire logic [2:0] trip_pole,
	input  wire logic       close_cmd,
	input  wire logic       manual_close_req,
	input  wire logic       channel_transmit_bit,
	input  wire logic       remote_permit,
	// Contacts and channel
	output logic [2:0]      pole_closed,
	output logic            channel_receive_bit
);
	int open_cnt [3];
	int close_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pole_closed <= 3'h0;
			close_cnt <= 0;
			channel_receive_bit <= 1'b0;
			for (int k = 0; k < 3; k++) open_cnt[k] <= 0;
		end else begin
			channel_receive_bit <= channel_transmit_bit & remote_permit;
			if (close_cmd || manual_close_req) close_cnt <= CLOSE_DLY;
			else if (close_cnt > 0) close_cnt <= close_cnt - 1;
			if (close_cnt == 1) pole_closed <= 3'h7;
			for (int k = 0; k < 3; k++) begin
				if (trip_pole[k] && pole_closed[k]) begin
					open_cnt[k] <= open_cnt[k] + 1;
					if (open_cnt[k] == OPEN_DLY) pole_closed[k] <= 1'b0;
				end else begin
					open_cnt[k] <= 0;
				end
			end
		end
	end
endmodule : breaker_remote_model

// File: test/single_pole_trip_reclose_bench.sv
// Self-checking bench for the single-pole trip and reclose block.
`timescale 1ns/10ps
module single_pole_trip_reclose_bench;
	import sptr_pkg::*;
	localparam int FC = 20;
	localparam int MC = 10;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	prot_ops_t   elem_ops;
	logic [2:0]  fault_type, pole_closed, trip_pole, bf_initiate, breaker_state;
	logic [2:0]  permissive_scheme_trip, selector_fault_ground, phase_open;
	pole_blk_t   pole_blk;
	logic        manual_close_req, channel_receive_bit, channel_transmit_bit, remote_permit;
	logic        single_pole_trip_flag, three_pole_trip_flag, selector_fault_multi;
	logic        element_reset, zero_seq_sup_removed, line_pickup_armed, recloser_enabled;
	logic        reclose_in_progress, force_three_pole_trip, close_cmd, lockout;
	int          errors, tests_run, cyc, i, t0;

	single_pole_trip_reclose #(.FORCE_CNT(FC), .MS_CNT(MC)) u_dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .elem_ops,
		.fault_type, .manual_close_req, .pole_closed, .channel_receive_bit,
		.channel_transmit_bit, .trip_pole, .single_pole_trip_flag, .three_pole_trip_flag,
		.bf_initiate, .breaker_state, .permissive_scheme_trip, .selector_fault_ground,
		.selector_fault_multi, .phase_open, .pole_blk, .element_reset, .zero_seq_sup_removed,
		.line_pickup_armed, .recloser_enabled, .reclose_in_progress, .force_three_pole_trip,
		.close_cmd, .lockout);

	breaker_remote_model u_far (.pclk, .presetn, .trip_pole, .close_cmd, .manual_close_req,
		.channel_transmit_bit, .remote_permit, .pole_closed, .channel_receive_bit);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp_d, input logic exp_e);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		check(q, exp_d);
		check({31'h0, e}, {31'h0, exp_e});
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_e);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		check({31'h0, e}, {31'h0, exp_e});
	endtask : wr

	task automatic manual_close();
		@(posedge pclk) manual_close_req <= 1'b1;
		@(posedge pclk) manual_close_req <= 1'b0;
	endtask : manual_close

	task automatic wait_trip();
		for (i = 0; i < 40 && trip_pole === 3'h0; i++) @(posedge pclk);
		t0 = cyc;
	endtask : wait_trip

	task automatic fault(input logic permissive_overreach_scheme);
		@(posedge pclk);
		fault_type <= FT_AG;
		elem_ops.disturbance_detector <= 1'b1;
		repeat (2) @(posedge pclk);
		check(selector_fault_ground, 3'h1);
		if (permissive_overreach_scheme) begin
			elem_ops.zone2_pickup <= 1'b1;
			remote_permit <= 1'b1;
			for (i = 0; i < 20 && channel_transmit_bit !== 1'b1; i++) @(posedge pclk);
			check(channel_transmit_bit, 1'b1);
			for (i = 0; i < 20 && permissive_scheme_trip === 3'h0; i++) @(posedge pclk);
			check(permissive_scheme_trip, 3'h1);
		end else begin
			elem_ops.ground_zone1_operate <= 1'b1;
		end
		wait_trip();
		check(trip_pole, 3'h1);
		check(single_pole_trip_flag, 1'b1);
		check(bf_initiate, 3'h1);
		check(phase_open, 3'h1);
		check(pole_blk, 4'hd);
		for (i = 0; i < 10 && element_reset !== 1'b1; i++) @(posedge pclk);
		check(element_reset, 1'b1);
		elem_ops <= 6'h01;
		fault_type <= FT_NONE;
		remote_permit <= 1'b0;
		repeat (3) @(posedge pclk);
		check(selector_fault_ground, 3'h0);
		check(reclose_in_progress, 1'b1);
		check(zero_seq_sup_removed, 1'b1);
		check(trip_pole, 3'h1);
		for (i = 0; i < 30 && trip_pole !== 3'h0; i++) @(posedge pclk);
		check(phase_open, 3'h1);
		for (i = 0; i < 60 && force_three_pole_trip !== 1'b1; i++) @(posedge pclk);
		check(cyc - t0 >= FC && cyc - t0 <= FC + 5, 1'b1);
		for (i = 0; i < 5 * MC + 100 && close_cmd !== 1'b1; i++) @(posedge pclk);
		check(close_cmd, 1'b1);
		for (i = 0; i < 40 && phase_open !== 3'h0; i++) @(posedge pclk);
		check(pole_blk, 4'h0);
	endtask : fault

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{manual_close_req, remote_permit, errors, tests_run} = '0;
		elem_ops = '0;
		fault_type = FT_NONE;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		check(recloser_enabled, 1'b1);
		check(breaker_state, 3'h0);
		check(line_pickup_armed, 1'b1);
		rd(CTRL_OFS, CTRL_RST, 1'b0);
		rd(DEAD_OFS, {16'h0, DEAD_RST}, 1'b0);
		rd(RESET_OFS, {16'h0, RESET_RST}, 1'b0);
		rd(MANBLK_OFS, {16'h0, MANBLK_RST}, 1'b0);
		rd(STATUS_OFS, 32'h0000_0080, 1'b0);
		fault_type <= FT_MULT;
		elem_ops.disturbance_detector <= 1'b1;
		repeat (2) @(posedge pclk);
		check(selector_fault_multi, 1'b1);
		check(selector_fault_ground, 3'h0);
		elem_ops.disturbance_detector <= 1'b0;
		fault_type <= FT_NONE;
		rd(8'h20, 32'h0, 1'b1);
		wr(8'h24, 32'h5, 1'b1);
		wr(DEAD_OFS, 32'h5, 1'b0);
		wr(RESET_OFS, 32'h14, 1'b0);
		wr(MANBLK_OFS, 32'h3, 1'b0);
		rd(DEAD_OFS, 32'h5, 1'b0);
		manual_close();
		repeat (3) @(posedge pclk);
		check(recloser_enabled, 1'b0);
		for (i = 0; i < 3 * MC + 40 && recloser_enabled !== 1'b1; i++) @(posedge pclk);
		check(recloser_enabled, 1'b1);
		check(breaker_state, 3'h7);
		elem_ops.line_voltage_normal <= 1'b1;
		repeat (3) @(posedge pclk);
		check(line_pickup_armed, 1'b0);
		fault(1'b0);
		for (i = 0; i < 20 * MC + 100 && reclose_in_progress !== 1'b0; i++) @(posedge pclk);
		check(force_three_pole_trip, 1'b0);
		fault(1'b1);
		fault_type <= FT_MULT;
		elem_ops.phase_zone1_operate <= 1'b1;
		wait_trip();
		check(trip_pole, 3'h7);
		check(three_pole_trip_flag, 1'b1);
		check(bf_initiate, 3'h7);
		for (i = 0; i < 20 && lockout !== 1'b1; i++) @(posedge pclk);
		check(lockout, 1'b1);
		elem_ops.phase_zone1_operate <= 1'b0;
		fault_type <= FT_NONE;
		wr(CTRL_OFS, 32'h13, 1'b0);
		repeat (3) @(posedge pclk);
		check(lockout, 1'b0);
		check(force_three_pole_trip, 1'b0);
		manual_close();
		repeat (8) @(posedge pclk);
		fault_type <= FT_AG;
		elem_ops.disturbance_detector <= 1'b1;
		elem_ops.ground_zone1_operate <= 1'b1;
		wait_trip();
		check(trip_pole, 3'h7);
		end_of_test();
	end
endmodule : single_pole_trip_reclose_bench

// File: verilog/single_pole_trip_reclose.sv
// Trip arbitration, open-pole blocking, phase selection and recloser with APB registers.
`timescale 1ns/10ps
module single_pole_trip_reclose
	import sptr_pkg::*;
#(
	parameter int FORCE_CNT = FORCE_CYCLES,
	parameter int MS_CNT    = MS_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Protection operands
	input  wire prot_ops_t   elem_ops,
	input  wire logic [2:0]  fault_type,
	input  wire logic        manual_close_req,
	// Breaker and channel pins
	input  wire logic [2:0]  pole_closed,
	input  wire logic        channel_receive_bit,
	output logic             channel_transmit_bit,
	// Trip output
	output logic [2:0]       trip_pole,
	output logic             single_pole_trip_flag,
	output logic             three_pole_trip_flag,
	output logic [2:0]       bf_initiate,
	output logic [2:0]       breaker_state,
	output logic [2:0]       permissive_scheme_trip,
	// Selector and open pole
	output logic [2:0]       selector_fault_ground,
	output logic             selector_fault_multi,
	output logic [2:0]       phase_open,
	output pole_blk_t        pole_blk,
	output logic             element_reset,
	output logic             zero_seq_sup_removed,
	output logic             line_pickup_armed,
	// Recloser
	output logic             recloser_enabled,
	output logic             reclose_in_progress,
	output logic             force_three_pole_trip,
	output logic             close_cmd,
	output logic             lockout
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	wire  [2:0] pole_closed_s = sync_r[2:0];
	wire        rx_s          = sync_r[3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 4'h7;
			sync_r <= 4'h7;
		end else begin
			meta_r <= {channel_receive_bit, pole_closed};
			sync_r <= meta_r;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] ctrl_r;
	logic [15:0] dead_r;
	logic [15:0] rst_time_r;
	logic [15:0] manblk_r;
	logic        clr_r;
	logic [31:0] status;

	wire setup   = psel & ~penable;
	wire wr_en   = psel & penable & pready & pwrite;
	wire hit_ctl = paddr == CTRL_OFS;
	wire hit_dd  = paddr == DEAD_OFS;
	wire hit_rt  = paddr == RESET_OFS;
	wire hit_mb  = paddr == MANBLK_OFS;
	wire hit_st  = paddr == STATUS_OFS;
	wire mapped  = hit_ctl | hit_dd | hit_rt | hit_mb | hit_st;
	wire [31:0] rd_mux = hit_ctl ? ctrl_r : hit_dd ? {16'h0000, dead_r} :
		hit_rt ? {16'h0000, rst_time_r} : hit_mb ? {16'h0000, manblk_r} :
		hit_st ? status : 32'h0000_0000;
	wire [2:0]  shots  = ctrl_r[SHOTS_LSB +: 3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r     <= CTRL_RST;
			dead_r     <= DEAD_RST;
			rst_time_r <= RESET_RST;
			manblk_r   <= MANBLK_RST;
			clr_r      <= 1'b0;
			pready     <= 1'b0;
			prdata     <= 32'h0000_0000;
			pslverr    <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			clr_r   <= wr_en & hit_ctl & pwdata[CTRL_CLR_BIT];
			if (setup)
				prdata <= rd_mux;
			if (wr_en & hit_ctl)
				ctrl_r <= pwdata & 32'h0000_0071;
			if (wr_en & hit_dd)
				dead_r <= pwdata[15:0];
			if (wr_en & hit_rt)
				rst_time_r <= pwdata[15:0];
			if (wr_en & hit_mb)
				manblk_r <= pwdata[15:0];
		end
	end

	// ----------------------------------------
	// Phase selector
	// ----------------------------------------
	logic [2:0] sel_gnd_r;
	logic       sel_mul_r;
	logic       single_r;
	logic       three_r;
	logic       rip_r;
	logic [2:0] trip_r;
	wire        sel_block = single_r | three_r | rip_r | (|trip_r);
	wire  [2:0] sel_gnd_nxt = {fault_type == FT_CG, fault_type == FT_BG, fault_type == FT_AG};
	wire        sel_mul_nxt = fault_type >= FT_MULT;
	wire        sel_run = elem_ops.disturbance_detector & ~sel_block;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_gnd_r <= 3'h0;
			sel_mul_r <= 1'b0;
		end else if (clr_r | ~sel_run) begin
			sel_gnd_r <= 3'h0;
			sel_mul_r <= 1'b0;
		end else begin
			sel_gnd_r <= sel_gnd_nxt;
			sel_mul_r <= sel_mul_nxt;
		end
	end

	// ----------------------------------------
	// Permissive overreach scheme
	// ----------------------------------------
	logic       force_r;
	logic [2:0] permissive_overreach_scheme_r;
	wire        fwd_pkp  = elem_ops.zone2_pickup | elem_ops.negseq_fwd_pickup;
	wire        permissive_overreach_scheme_go  = rx_s & fwd_pkp;
	wire  [2:0] permissive_overreach_scheme_nxt = permissive_overreach_scheme_go ? (sel_mul_r ? 3'h7 : sel_gnd_r) : 3'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			permissive_overreach_scheme_r               <= 3'h0;
			channel_transmit_bit <= 1'b0;
		end else begin
			permissive_overreach_scheme_r               <= clr_r ? 3'h0 : permissive_overreach_scheme_nxt;
			channel_transmit_bit <= ~clr_r & (fwd_pkp | force_r);
		end
	end

	// ----------------------------------------
	// Trip output
	// ----------------------------------------
	logic [2:0] open_r;
	logic       en_r;
	wire        req_any  = elem_ops.ground_zone1_operate | elem_ops.phase_zone1_operate |
		(|permissive_overreach_scheme_r);
	wire        hold_off = (|open_r) & ~force_r;
	wire        go_three = ~en_r | force_r | sel_mul_r | (sel_gnd_r == 3'h0);
	wire  [2:0] tgt      = go_three ? 3'h7 : sel_gnd_r;
	wire        issue    = req_any & ~hold_off & ((trip_r == 3'h0) | (go_three & single_r));
	wire  [2:0] trip_nxt = (issue ? tgt : 3'h0) | (trip_r & pole_closed_s);
	wire        single_nxt = issue ? ~go_three : single_r & (|trip_nxt);
	wire        three_nxt  = issue ? go_three : three_r & (|trip_nxt);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_r        <= 3'h0;
			single_r      <= 1'b0;
			three_r       <= 1'b0;
			bf_initiate   <= 3'h0;
			breaker_state <= 3'h7;
		end else if (clr_r) begin
			trip_r      <= 3'h0;
			single_r    <= 1'b0;
			three_r     <= 1'b0;
			bf_initiate <= 3'h0;
		end else begin
			trip_r        <= trip_nxt;
			single_r      <= single_nxt;
			three_r       <= three_nxt;
			bf_initiate   <= trip_nxt;
			breaker_state <= pole_closed_s;
		end
	end

	// ----------------------------------------
	// Open pole detector
	// ----------------------------------------
	wire [2:0] open_nxt = ((issue & ~go_three) ? tgt : 3'h0) |
		(open_r & (trip_r | ~pole_closed_s));
	wire       spt_rise = single_nxt & ~single_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_r        <= 3'h0;
			pole_blk      <= '0;
			element_reset <= 1'b0;
		end else if (clr_r | (issue & go_three)) begin
			open_r        <= 3'h0;
			pole_blk      <= '0;
			element_reset <= 1'b0;
		end else begin
			open_r                          <= open_nxt;
			pole_blk.residual_oc_block      <= |open_nxt;
			pole_blk.loop_ab_distance_block <= open_nxt[0] | open_nxt[1];
			pole_blk.loop_bc_distance_block <= open_nxt[1] | open_nxt[2];
			pole_blk.loop_ca_distance_block <= open_nxt[2] | open_nxt[0];
			element_reset                   <= spt_rise;
		end
	end

	// ----------------------------------------
	// Recloser
	// ----------------------------------------
	ar_state_t   st_r;
	ar_state_t   st_nxt;
	logic [15:0] divc_r;
	logic [15:0] tmr_r;
	logic [18:0] fcnt_r;
	logic [2:0]  shot_r;
	logic        close_r;
	wire         ms_tick   = divc_r == 16'(MS_CNT - 1);
	wire         mb_done   = st_r == AR_MANBLK && tmr_r >= manblk_r;
	wire         dead_done = st_r == AR_DEAD && tmr_r >= dead_r;
	wire         rst_done  = st_r == AR_RECLAIM && tmr_r >= rst_time_r;
	wire         fault_mb  = elem_ops.disturbance_detector | req_any;
	wire         shots_out = shot_r >= shots;
	wire         force_hit = fcnt_r == 19'(FORCE_CNT - 1);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			AR_IDLE:    if (manual_close_req) st_nxt = AR_MANBLK;
				else if (issue) st_nxt = (shots == 3'h0) ? AR_LOCKOUT : AR_DEAD;
			AR_MANBLK:  if (issue) st_nxt = AR_LOCKOUT;
				else if (mb_done & ~fault_mb) st_nxt = AR_IDLE;
			AR_DEAD:    if (dead_done) st_nxt = AR_RECLAIM;
			AR_RECLAIM: if (issue) st_nxt = shots_out ? AR_LOCKOUT : AR_DEAD;
				else if (rst_done) st_nxt = AR_IDLE;
			AR_LOCKOUT: if (manual_close_req) st_nxt = AR_MANBLK;
			default:    st_nxt = AR_LOCKOUT;
		endcase
		if (manual_close_req)
			st_nxt = AR_MANBLK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r    <= AR_IDLE;
			divc_r  <= 16'h0000;
			tmr_r   <= 16'h0000;
			fcnt_r  <= 19'h00000;
			shot_r  <= 3'h0;
			force_r <= 1'b0;
			close_r <= 1'b0;
		end else if (clr_r) begin
			st_r    <= AR_IDLE;
			divc_r  <= 16'h0000;
			tmr_r   <= 16'h0000;
			fcnt_r  <= 19'h00000;
			shot_r  <= 3'h0;
			force_r <= 1'b0;
			close_r <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			divc_r  <= ms_tick ? 16'h0000 : divc_r + 16'h0001;
			close_r <= dead_done;
			if (st_nxt != st_r)
				tmr_r <= 16'h0000;
			else if (ms_tick && tmr_r != 16'hffff)
				tmr_r <= tmr_r + 16'h0001;
			if (st_nxt == AR_IDLE || st_nxt == AR_LOCKOUT || st_nxt == AR_MANBLK)
				shot_r <= 3'h0;
			else if (st_nxt == AR_DEAD && st_r != AR_DEAD)
				shot_r <= shot_r + 3'h1;
			if (st_nxt == AR_IDLE || st_nxt == AR_MANBLK) begin
				force_r <= 1'b0;
				fcnt_r  <= 19'h00000;
			end else if (st_r == AR_IDLE && st_nxt == AR_DEAD) begin
				fcnt_r <= 19'h00000;
			end else if ((st_r == AR_DEAD || st_r == AR_RECLAIM) && !force_r) begin
				fcnt_r  <= fcnt_r + 19'h00001;
				force_r <= force_hit;
			end
		end
	end

	assign en_r  = ctrl_r[CTRL_EN_BIT] && st_r != AR_MANBLK && st_r != AR_LOCKOUT;
	assign rip_r = st_r == AR_DEAD || st_r == AR_RECLAIM;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recloser_enabled      <= 1'b0;
			reclose_in_progress   <= 1'b0;
			force_three_pole_trip <= 1'b0;
			zero_seq_sup_removed  <= 1'b0;
			close_cmd             <= 1'b0;
			lockout               <= 1'b0;
			line_pickup_armed     <= 1'b0;
		end else begin
			recloser_enabled      <= en_r;
			reclose_in_progress   <= rip_r;
			force_three_pole_trip <= force_r;
			zero_seq_sup_removed  <= rip_r;
			close_cmd             <= close_r;
			lockout               <= st_r == AR_LOCKOUT;
			line_pickup_armed     <= ~elem_ops.line_voltage_normal;
		end
	end

	assign trip_pole              = trip_r;
	assign single_pole_trip_flag  = single_r;
	assign three_pole_trip_flag   = three_r;
	assign phase_open             = open_r;
	assign permissive_scheme_trip = permissive_overreach_scheme_r;
	assign selector_fault_ground  = sel_gnd_r;
	assign selector_fault_multi   = sel_mul_r;
	assign status = {18'h00000, shot_r, st_r == AR_LOCKOUT, force_r, rip_r, en_r, 1'b0,
		open_r, trip_r};

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_disabled_three_pole: assert property (issue && !en_r |=> trip_r == 3'h7)
		else $error("single trip while recloser disabled");
	a_flag_with_trip: assert property ($rose(single_r) |-> (|trip_r) && !three_r)
		else $error("single flag without pole command");
	a_open_at_trip: assert property ($rose(single_r) && trip_r[0] |-> open_r[0])
		else $error("phase A not declared open at trip");
	a_trip_held: assert property (trip_r[0] && pole_closed_s[0] && !clr_r |=> trip_r[0])
		else $error("pole A trip dropped before pole opened");
	a_open_blocks: assert property ($rose(open_r[0]) |-> pole_blk.residual_oc_block
		&& pole_blk.loop_ab_distance_block && pole_blk.loop_ca_distance_block)
		else $error("open phase A did not block elements");
	a_selector_reset: assert property (single_r || rip_r |=> sel_gnd_r == 3'h0)
		else $error("selector output during trip or reclose");
	a_force_time: assert property ($rose(force_r) |-> $past(fcnt_r) == 19'(FORCE_CNT - 1))
		else $error("force three-pole at wrong time");
	a_force_three: assert property (issue && force_r |=> three_r && trip_r == 3'h7)
		else $error("trip under force was not three-pole");
	a_key_permission: assert property (fwd_pkp && !clr_r |=> channel_transmit_bit)
		else $error("permission bit not keyed");
	a_close_after_dead: assert property (close_r |-> st_r == AR_RECLAIM)
		else $error("close command outside dead time end");

	c_single_trip: cover property ($rose(single_r));
	c_force_set: cover property ($rose(force_r));
	c_close: cover property (close_cmd);
	c_lockout: cover property ($rose(lockout));
	c_multi_selected: cover property (sel_mul_r);

endmodule : single_pole_trip_reclose

// File: verilog/sptr_pkg.sv
// Constants, types and register map of the single-pole trip and reclose block.
// How it works
// - Manual close disables recloser, starts block timer.
// - Recloser disabled turns single trips into three-pole.
// - Block timer expiry without fault re-enables recloser.
// - Breaker pole states reach the trip output and the open pole detector.
// - Line pickup armed while line is dead.
// - Disturbance pickup lets selector report fault type.
// - Phase A ground fault trips pole A only.
// - Single-pole flag rises with pole trip command.
// - Open pole declared at single-pole trip, then by position.
// - Pole trip held until auxiliary contact shows open.
// - Open phase A blocks residual, AB, CA.
// - Zone 2 or negative-sequence pickup keys permission bit.
// - Received permission trips selector phase like zone 1.
// - Single flag resets selector and picked-up elements.
// - Single flag starts reclose, in-progress blocks selector.
// - Reclose in progress removes zero-sequence supervision.
// - Force three-pole trip exactly 8 ms after initiation.
// - Dead time end commands breaker close.
// - Reclosed pole drops all open-pole blocking.
// - Reset time clears force and in-progress.
// - Trip under force is always three-pole.
// - Lockout on initiation once shots are used.
// - Breaker failure initiated per tripped phase.
package sptr_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0]  CTRL_OFS     = 8'h00;
	localparam logic [7:0]  DEAD_OFS     = 8'h04;
	localparam logic [7:0]  RESET_OFS    = 8'h08;
	localparam logic [7:0]  MANBLK_OFS   = 8'h0c;
	localparam logic [7:0]  STATUS_OFS   = 8'h10;
	localparam int          CTRL_EN_BIT  = 0;
	localparam int          CTRL_CLR_BIT = 1;
	localparam int          SHOTS_LSB    = 4;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0011;
	localparam logic [15:0] DEAD_RST     = 16'h01f4;
	localparam logic [15:0] RESET_RST    = 16'h0bb8;
	localparam logic [15:0] MANBLK_RST   = 16'h03e8;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ        = 40_000_000;
	localparam int FORCE_TIME_MS = 8;
	localparam int FORCE_CYCLES  = FORCE_TIME_MS * (CLK_HZ / 1000);
	localparam int MS_CYCLES     = CLK_HZ / 1000;

	// ----------------------------------------
	// Fault type codes from the selector analysis
	// ----------------------------------------
	localparam logic [2:0] FT_NONE = 3'h0;
	localparam logic [2:0] FT_AG   = 3'h1;
	localparam logic [2:0] FT_BG   = 3'h2;
	localparam logic [2:0] FT_CG   = 3'h3;
	localparam logic [2:0] FT_MULT = 3'h4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		AR_IDLE = 3'b000, AR_DEAD = 3'b001, AR_RECLAIM = 3'b011,
		AR_LOCKOUT = 3'b010, AR_MANBLK = 3'b110
	} ar_state_t;

	typedef struct packed {
		logic ground_zone1_operate;
		logic phase_zone1_operate;
		logic zone2_pickup;
		logic negseq_fwd_pickup;
		logic disturbance_detector;
		logic line_voltage_normal;
	} prot_ops_t;

	typedef struct packed {
		logic residual_oc_block;
		logic loop_ab_distance_block;
		logic loop_bc_distance_block;
		logic loop_ca_distance_block;
	} pole_blk_t;

endpackage : sptr_pkg
